// ### include/i2c_cmd_defs.svh
// Purpose: Constants for the I2C command write link
// Assumes: 50 MHz mclk, open-drain SCL and SDA
// Notes: Function list below
//
// Function
// [RULE_01] Address bits sampled on SCL rise
// [RULE_02] Data bits sampled on SCL rise
// [RULE_03] Client acknowledges address on ninth clock
// [RULE_04] Client acknowledges each data byte, ninth clock
// [RULE_05] Client may stretch; host waits SCL high
// [RULE_06] Both lines idle high between transfers
// [RULE_07] Start: SDA falls, then SCL falls
// [RULE_08] Seven address bits plus write bit zero
// [RULE_09] Acknowledge only on address match
// [RULE_10] Host sends bytes MSB first
// [RULE_11] Client holds SDA low across ack pulse
// [RULE_12] Repeat stretch, byte, ack per byte
// [RULE_13] Stop: SCL rises, then SDA rises
// [RULE_14] Host checks message size field
// [RULE_15] Host stops exactly at message length
// [RULE_16] Client address is 0x42
// [RULE_17] Mismatch: stay released until next start
`ifndef I2C_CMD_DEFS_SVH
`define I2C_CMD_DEFS_SVH
`define CLIENT_ADDR 7'h42
`define WRITE_DIR 1'b0
`define MCLK_NS 20
`define HALF_BIT_NS 1250
`define HALF_BIT_CYC ((`HALF_BIT_NS + `MCLK_NS - 1) / `MCLK_NS)
`define STRETCH_CYC 16
`endif

// ### include/i2c_cmd_pkg.sv
// Purpose: Types for the I2C command write link
// Assumes: Nothing
// Notes: States of both ends
package i2c_cmd_pkg;
    typedef enum logic [2:0] {
        C_IDLE = 3'b000,
        C_ADDR = 3'b001,
        C_AACK = 3'b010,
        C_DATA = 3'b011,
        C_DACK = 3'b100,
        C_SKIP = 3'b101
    } client_state_t;
    typedef enum logic [3:0] {
        H_IDLE = 4'b0000,
        H_START = 4'b0001,
        H_LOW = 4'b0010,
        H_HIGH = 4'b0011,
        H_WAIT = 4'b0100,
        H_STOP0 = 4'b0101,
        H_STOP1 = 4'b0110,
        H_STOP2 = 4'b0111,
        H_FETCH = 4'b1000
    } host_state_t;
endpackage

// ### include/i2c_cmd_if.sv
// Purpose: Open-drain SCL and SDA shared by host and client
// Assumes: Pull-ups resolve undriven lines high
// Notes: Wire levels worked out from enables
`timescale 1ns/1ps
interface i2c_cmd_if;
    logic scl_host_oe;
    logic sda_host_oe;
    logic scl_client_oe;
    logic sda_client_oe;
    logic scl;
    logic sda;
    assign scl = !(scl_host_oe || scl_client_oe);
    assign sda = !(sda_host_oe || sda_client_oe);
    modport host (input scl, input sda, output scl_host_oe, output sda_host_oe);
    modport client (input scl, input sda, output scl_client_oe, output sda_client_oe);
endinterface

// ### verilog/i2c_cmd_client.sv
// Purpose: I2C client receiving command write bytes
// Assumes: SCL and SDA asynchronous to mclk
// Notes: Reads are answered with no acknowledge
`timescale 1ns/1ps
`include "i2c_cmd_defs.svh"
module i2c_cmd_client (
    input wire logic mclk,
    input wire logic arst_n,
    i2c_cmd_if.client bus,
    input wire logic stall,
    output logic [7:0] rx_data,
    output logic rx_valid,
    output logic rx_start,
    output logic rx_stop
);
    import i2c_cmd_pkg::*;
    logic [2:0] scl_sync_reg;
    logic [2:0] sda_sync_reg;
    logic scl_reg;
    logic sda_reg;
    client_state_t state_reg;
    logic [3:0] bit_cnt_reg;
    logic [7:0] shift_reg;
    logic scl_oe_reg;
    logic sda_oe_reg;
    logic [7:0] stretch_cnt_reg;
    logic scl_rise;
    logic scl_fall;
    logic start_seen;
    logic stop_seen;

    // Three-stage sync, change accepted when stages two and three agree
    always_ff @(posedge mclk or negedge arst_n) begin
        if (!arst_n) begin
            scl_sync_reg <= 3'h7;
            sda_sync_reg <= 3'h7;
            scl_reg <= 1'b1;
            sda_reg <= 1'b1;
        end else begin
            scl_sync_reg <= {scl_sync_reg[1:0], bus.scl};
            sda_sync_reg <= {sda_sync_reg[1:0], bus.sda};
            if (scl_sync_reg[1] == scl_sync_reg[2]) begin
                scl_reg <= scl_sync_reg[2];
            end
            if (sda_sync_reg[1] == sda_sync_reg[2]) begin
                sda_reg <= sda_sync_reg[2];
            end
        end
    end

    assign scl_rise = (scl_sync_reg[1] == scl_sync_reg[2]) && scl_sync_reg[2] && !scl_reg;
    assign scl_fall = (scl_sync_reg[1] == scl_sync_reg[2]) && !scl_sync_reg[2] && scl_reg;
    // Start and stop: SDA moves while SCL high
    assign start_seen = scl_reg && scl_sync_reg[2] && sda_reg && (sda_sync_reg[1] == sda_sync_reg[2])
        && !sda_sync_reg[2]; // [RULE_07]
    assign stop_seen = scl_reg && scl_sync_reg[2] && !sda_reg && (sda_sync_reg[1] == sda_sync_reg[2])
        && sda_sync_reg[2]; // [RULE_13]

    // Protocol sequencer
    always_ff @(posedge mclk or negedge arst_n) begin
        if (!arst_n) begin
            state_reg <= C_IDLE;
            bit_cnt_reg <= 4'h0;
            shift_reg <= 8'h00;
        end else if (start_seen) begin
            state_reg <= C_ADDR;
            bit_cnt_reg <= 4'h0;
        end else if (stop_seen) begin
            state_reg <= C_IDLE; // [RULE_06]
        end else begin
            case (state_reg)
                C_ADDR, C_DATA: begin
                    if (scl_rise) begin
                        shift_reg <= {shift_reg[6:0], sda_reg}; // [RULE_01] [RULE_02] [RULE_10]
                        bit_cnt_reg <= bit_cnt_reg + 4'h1;
                    end
                    if (scl_fall && bit_cnt_reg == 4'h8) begin
                        bit_cnt_reg <= 4'h0;
                        if (state_reg == C_DATA) begin
                            state_reg <= C_DACK; // [RULE_04]
                        end else if (shift_reg == {`CLIENT_ADDR, `WRITE_DIR}) begin
                            state_reg <= C_AACK; // [RULE_09] [RULE_16] [RULE_08]
                        end else begin
                            state_reg <= C_SKIP; // [RULE_17]
                        end
                    end
                end
                C_AACK, C_DACK: begin
                    if (scl_fall && scl_oe_reg == 1'b0) begin
                        state_reg <= C_DATA; // [RULE_12]
                    end
                end
                C_SKIP: begin
                    state_reg <= C_SKIP;
                end
                default: begin
                    state_reg <= C_IDLE;
                end
            endcase
        end
    end

    // Acknowledge drive through the ninth clock
    always_ff @(posedge mclk or negedge arst_n) begin
        if (!arst_n) begin
            sda_oe_reg <= 1'b0;
        end else if (start_seen || stop_seen) begin
            sda_oe_reg <= 1'b0;
        end else if (state_reg == C_ADDR && scl_fall && bit_cnt_reg == 4'h8) begin
            sda_oe_reg <= (shift_reg == {`CLIENT_ADDR, `WRITE_DIR}); // [RULE_03] [RULE_09]
        end else if (state_reg == C_DATA && scl_fall && bit_cnt_reg == 4'h8) begin
            sda_oe_reg <= 1'b1; // [RULE_11]
        end else if ((state_reg == C_AACK || state_reg == C_DACK) && scl_fall && !scl_oe_reg) begin
            sda_oe_reg <= 1'b0;
        end
    end

    // Stretch SCL low after ninth clock for STRETCH_CYC cycles, then while user stalls
    always_ff @(posedge mclk or negedge arst_n) begin
        if (!arst_n) begin
            scl_oe_reg <= 1'b0;
            stretch_cnt_reg <= 8'h00;
        end else if (start_seen || stop_seen) begin
            scl_oe_reg <= 1'b0;
            stretch_cnt_reg <= 8'h00;
        end else if ((state_reg == C_AACK || state_reg == C_DACK) && scl_fall) begin
            scl_oe_reg <= 1'b1; // [RULE_05]
            stretch_cnt_reg <= 8'(`STRETCH_CYC);
        end else if (scl_oe_reg) begin
            if (stretch_cnt_reg != 8'h00) begin
                stretch_cnt_reg <= stretch_cnt_reg - 8'h01;
            end else if (!stall) begin
                scl_oe_reg <= 1'b0;
            end
        end
    end

    // User side
    always_ff @(posedge mclk or negedge arst_n) begin
        if (!arst_n) begin
            rx_data <= 8'h00;
            rx_valid <= 1'b0;
            rx_start <= 1'b0;
            rx_stop <= 1'b0;
        end else begin
            rx_valid <= state_reg == C_DATA && scl_fall && bit_cnt_reg == 4'h8 && !start_seen && !stop_seen;
            if (state_reg == C_DATA && scl_fall && bit_cnt_reg == 4'h8) begin
                rx_data <= shift_reg;
            end
            rx_start <= state_reg == C_ADDR && scl_fall && bit_cnt_reg == 4'h8 && !start_seen && !stop_seen
                && shift_reg == {`CLIENT_ADDR, `WRITE_DIR};
            rx_stop <= stop_seen && state_reg != C_IDLE && state_reg != C_SKIP;
        end
    end

    assign bus.scl_client_oe = scl_oe_reg;
    assign bus.sda_client_oe = sda_oe_reg;
endmodule

// ### verilog/i2c_cmd_host.sv
// Purpose: I2C host writing a command message
// Assumes: SCL and SDA asynchronous inputs, resolved by pull-ups
// Notes: SCL derived from mclk by divider
`timescale 1ns/1ps
`include "i2c_cmd_defs.svh"
module i2c_cmd_host #(
    parameter int HALF_CYC = `HALF_BIT_CYC
) (
    input wire logic mclk,
    input wire logic arst_n,
    i2c_cmd_if.host bus,
    input wire logic [6:0] target_addr,
    input wire logic [7:0] msg_len,
    input wire logic go,
    input wire logic [7:0] tx_data,
    output logic tx_take,
    output logic busy,
    output logic nack
);
    import i2c_cmd_pkg::*;
    logic [2:0] scl_sync_reg;
    logic [2:0] sda_sync_reg;
    logic scl_reg;
    logic sda_reg;
    host_state_t state_reg;
    logic [15:0] tmr_reg;
    logic [3:0] bit_reg;
    logic [8:0] sh_reg;
    logic [7:0] left_reg;
    logic scl_oe_reg;
    logic sda_oe_reg;
    logic ack_phase;

    always_ff @(posedge mclk or negedge arst_n) begin
        if (!arst_n) begin
            scl_sync_reg <= 3'h7;
            sda_sync_reg <= 3'h7;
            scl_reg <= 1'b1;
            sda_reg <= 1'b1;
        end else begin
            scl_sync_reg <= {scl_sync_reg[1:0], bus.scl};
            sda_sync_reg <= {sda_sync_reg[1:0], bus.sda};
            if (scl_sync_reg[1] == scl_sync_reg[2]) begin
                scl_reg <= scl_sync_reg[2];
            end
            if (sda_sync_reg[1] == sda_sync_reg[2]) begin
                sda_reg <= sda_sync_reg[2];
            end
        end
    end

    assign ack_phase = bit_reg == 4'h8;

    always_ff @(posedge mclk or negedge arst_n) begin
        if (!arst_n) begin
            state_reg <= H_IDLE;
            tmr_reg <= 16'h0000;
            bit_reg <= 4'h0;
            sh_reg <= 9'h1FF;
            left_reg <= 8'h00;
            scl_oe_reg <= 1'b0;
            sda_oe_reg <= 1'b0;
            tx_take <= 1'b0;
            busy <= 1'b0;
            nack <= 1'b0;
        end else begin
            tx_take <= 1'b0;
            if (tmr_reg != 16'h0000) begin
                tmr_reg <= tmr_reg - 16'h0001;
            end else begin
                case (state_reg)
                    H_IDLE: begin
                        scl_oe_reg <= 1'b0; // [RULE_06]
                        sda_oe_reg <= 1'b0;
                        if (go) begin
                            busy <= 1'b1;
                            nack <= 1'b0;
                            sda_oe_reg <= 1'b1; // [RULE_07]
                            sh_reg <= {target_addr, `WRITE_DIR, 1'b1}; // [RULE_08]
                            left_reg <= msg_len; // [RULE_14]
                            bit_reg <= 4'h0;
                            tmr_reg <= 16'(HALF_CYC);
                            state_reg <= H_START;
                        end
                    end
                    H_START: begin
                        scl_oe_reg <= 1'b1;
                        tmr_reg <= 16'(HALF_CYC);
                        state_reg <= H_LOW;
                    end
                    H_LOW: begin
                        // Data set up a half period before SCL is released
                        sda_oe_reg <= !sh_reg[8]; // [RULE_10]
                        tmr_reg <= 16'(HALF_CYC);
                        state_reg <= H_WAIT;
                    end
                    H_WAIT: begin
                        scl_oe_reg <= 1'b0;
                        if (scl_reg) begin
                            tmr_reg <= 16'(HALF_CYC); // [RULE_05]
                            state_reg <= H_HIGH;
                        end
                    end
                    H_HIGH: begin
                        scl_oe_reg <= 1'b1;
                        tmr_reg <= 16'(HALF_CYC);
                        sh_reg <= {sh_reg[7:0], 1'b1};
                        if (ack_phase) begin
                            bit_reg <= 4'h0;
                            if (sda_reg) begin
                                nack <= 1'b1;
                                state_reg <= H_STOP0;
                            end else if (left_reg == 8'h00) begin
                                state_reg <= H_STOP0; // [RULE_15]
                            end else begin
                                state_reg <= H_FETCH; // [RULE_12]
                            end
                        end else begin
                            bit_reg <= bit_reg + 4'h1;
                            state_reg <= H_LOW;
                        end
                    end
                    H_FETCH: begin
                        sh_reg <= {tx_data, 1'b1};
                        tx_take <= 1'b1;
                        left_reg <= left_reg - 8'h01;
                        state_reg <= H_LOW;
                    end
                    H_STOP0: begin
                        sda_oe_reg <= 1'b1;
                        tmr_reg <= 16'(HALF_CYC);
                        state_reg <= H_STOP1;
                    end
                    H_STOP1: begin
                        scl_oe_reg <= 1'b0; // [RULE_13]
                        tmr_reg <= 16'(HALF_CYC);
                        state_reg <= H_STOP2;
                    end
                    H_STOP2: begin
                        if (scl_reg) begin
                            sda_oe_reg <= 1'b0;
                            tmr_reg <= 16'(HALF_CYC);
                            busy <= 1'b0;
                            state_reg <= H_IDLE;
                        end
                    end
                    default: begin
                        state_reg <= H_IDLE;
                    end
                endcase
            end
        end
    end

    assign bus.scl_host_oe = scl_oe_reg;
    assign bus.sda_host_oe = sda_oe_reg;
endmodule

// ### tb/i2c_cmd_link_chk.sv
// Purpose: Checker on the shared SCL and SDA wires
// Assumes: One mclk domain, both ends on one interface
// Notes: Sees wire levels and the four enables only
`timescale 1ns/1ps
module i2c_cmd_link_chk (
    input wire logic mclk,
    input wire logic arst_n,
    input wire logic scl,
    input wire logic sda,
    input wire logic scl_host_oe,
    input wire logic sda_host_oe,
    input wire logic scl_client_oe,
    input wire logic sda_client_oe
);
    logic scl_reg;
    logic sda_reg;
    logic [3:0] rise_cnt_reg;
    default clocking cb @(posedge mclk); endclocking
    default disable iff (!arst_n);
    // SCL rises counted within a byte
    always_ff @(posedge mclk or negedge arst_n) begin
        if (!arst_n) begin
            scl_reg <= 1'b1;
            sda_reg <= 1'b1;
            rise_cnt_reg <= 4'h0;
        end else begin
            scl_reg <= scl;
            sda_reg <= sda;
            if (sda_reg && !sda && scl)
                rise_cnt_reg <= 4'h0;
            else if (scl && !scl_reg)
                rise_cnt_reg <= (rise_cnt_reg == 4'h8) ? 4'h0 : rise_cnt_reg + 4'h1;
        end
    end
    sequence start_seen;
        $fell(sda) && scl;
    endsequence
    sequence stop_seen;
        $rose(sda) && scl;
    endsequence
    a_start_order: assert property (start_seen |-> ##[1:20] !scl)
        else $error("scl did not fall after start");
    a_stop_order: assert property (stop_seen |-> $past(scl) && $past(scl, 2))
        else $error("sda rose before scl was high");
    a_idle_high: assert property (stop_seen |=> scl && sda && !scl_host_oe && !sda_host_oe)
        else $error("lines not idle after stop");
    a_stretch_low: assert property ($rose(scl_client_oe) |-> !$past(scl))
        else $error("client pulled scl while high");
    a_stretch_min: assert property ($rose(scl_client_oe) |-> scl_client_oe [*8])
        else $error("stretch too short");
    a_host_waits: assert property (!scl_host_oe && !scl |=> !scl_host_oe)
        else $error("host clocked during stretch");
    a_ack_stable: assert property ($changed(sda_client_oe) |-> !scl && !$past(scl))
        else $error("client sda changed while scl high");
    a_ack_ninth: assert property (scl && !scl_reg && sda_client_oe |-> rise_cnt_reg == 4'h8)
        else $error("client ack outside ninth clock");
endmodule

// ### tb/i2c_client_command_write_tb.sv
// Purpose: Host and client on one link, command writes checked
// Assumes: HALF_CYC of 4 shortens the bit time
// Notes: Expected bytes come from each call's arguments
`timescale 1ns/1ps
module i2c_client_command_write_tb;
    logic mclk = 1'b0;
    logic arst_n = 1'b0;
    logic stall = 1'b0;
    logic go = 1'b0;
    logic [6:0] target_addr = 7'h00;
    logic [7:0] msg_len = 8'h00;
    logic [7:0] msg [0:3] = '{default: 8'h00};
    logic [1:0] idx = 2'h0;
    logic [7:0] got [0:3];
    logic [7:0] rx_data;
    logic rx_valid, rx_start, rx_stop, tx_take, busy, nack;
    int rx_cnt = 0;
    int start_cnt = 0;
    int stop_cnt = 0;
    int mismatches = 0;
    int total_checks = 0;
    i2c_cmd_if bus ();
    i2c_cmd_host #(.HALF_CYC(4)) u_i2c_cmd_host (.mclk(mclk), .arst_n(arst_n), .bus(bus.host),
        .target_addr(target_addr), .msg_len(msg_len), .go(go), .tx_data(msg[idx]), .tx_take(tx_take),
        .busy(busy), .nack(nack));
    i2c_cmd_client u_i2c_cmd_client (.mclk(mclk), .arst_n(arst_n), .bus(bus.client), .stall(stall),
        .rx_data(rx_data), .rx_valid(rx_valid), .rx_start(rx_start), .rx_stop(rx_stop));
    i2c_cmd_link_chk u_i2c_cmd_link_chk (.mclk(mclk), .arst_n(arst_n), .scl(bus.scl), .sda(bus.sda),
        .scl_host_oe(bus.scl_host_oe), .sda_host_oe(bus.sda_host_oe), .scl_client_oe(bus.scl_client_oe),
        .sda_client_oe(bus.sda_client_oe));
    always #10 mclk = ~mclk;
    // Next byte offered once the host takes one
    always @(negedge mclk) begin
        if (tx_take === 1'b1)
            idx <= idx + 2'h1;
    end
    always @(posedge mclk) begin
        if (rx_valid === 1'b1) begin
            got[rx_cnt[1:0]] = rx_data;
            rx_cnt = rx_cnt + 1;
        end
        if (rx_start === 1'b1)
            start_cnt = start_cnt + 1;
        if (rx_stop === 1'b1)
            stop_cnt = stop_cnt + 1;
    end
    task automatic chk(input string what, input logic [7:0] exp, input logic [7:0] seen);
        total_checks++;
        if (seen !== exp) begin
            mismatches++;
            $display("unexpected %s: expected %h, seen %h", what, exp, seen);
        end
    endtask
    task automatic close_out();
        $display("checks %0d, mismatches %0d", total_checks, mismatches);
        if (mismatches == 0 && total_checks > 0)
            $display("All tests passed");
        else
            $display("Some tests failed");
        $finish;
    endtask
    // One write message from go to the end of busy
    task automatic send(input logic [6:0] a, input logic [7:0] n, input logic [7:0] b0, input logic [7:0] b1,
        input logic [7:0] b2, input logic exp_nack);
        int i;
        @(negedge mclk);
        target_addr = a;
        msg_len = n;
        msg = '{b0, b1, b2, 8'h00};
        idx = 2'h0;
        rx_cnt = 0;
        start_cnt = 0;
        stop_cnt = 0;
        go = 1'b1;
        @(negedge mclk);
        for (i = 0; i < 50 && busy !== 1'b1; i++)
            @(negedge mclk);
        go = 1'b0;
        chk("busy", 8'h01, {7'h00, busy});
        for (i = 0; i < 5000 && busy !== 1'b0; i++)
            @(negedge mclk);
        if (i == 5000) begin
            mismatches++;
            close_out();
        end
        for (i = 0; i < 20 && stop_cnt != (exp_nack ? 0 : 1); i++)
            @(negedge mclk);
        chk("nack", {7'h00, exp_nack}, {7'h00, nack});
        chk("start count", exp_nack ? 8'h00 : 8'h01, start_cnt[7:0]);
        chk("stop count", exp_nack ? 8'h00 : 8'h01, stop_cnt[7:0]);
        chk("byte count", exp_nack ? 8'h00 : n, rx_cnt[7:0]);
        for (i = 0; i < 3; i++)
            if (!exp_nack && i < n)
                chk("byte", msg[i], got[i]);
        chk("idle lines", 8'h03, {6'h00, bus.scl, bus.sda});
    endtask
    initial begin
        logic [6:0] bad [0:3];
        bad = '{7'h43, 7'h40, 7'h02, 7'h21};
        #60 arst_n = 1'b1;
        repeat (3) @(negedge mclk);
        send(7'h42, 8'h03, 8'h81, 8'h00, 8'hFF, 1'b0);
        send(7'h42, 8'h01, 8'hA5, 8'h00, 8'h00, 1'b0);
        send(7'h42, 8'h00, 8'h00, 8'h00, 8'h00, 1'b0);
        foreach (bad[k])
            send(bad[k], 8'h02, 8'h11, 8'h22, 8'h00, 1'b1);
        stall = 1'b1;
        fork
            send(7'h42, 8'h02, 8'h3C, 8'hC3, 8'h00, 1'b0);
            begin
                repeat (300) @(negedge mclk);
                chk("stretched scl", 8'h00, {7'h00, bus.scl});
                stall = 1'b0;
            end
        join
        target_addr = 7'h42;
        msg_len = 8'h03;
        go = 1'b1;
        repeat (60) @(negedge mclk);
        go = 1'b0;
        arst_n = 1'b0;
        @(negedge mclk);
        chk("lines in reset", 8'h03, {6'h00, bus.scl, bus.sda});
        arst_n = 1'b1;
        repeat (3) @(negedge mclk);
        send(7'h42, 8'h02, 8'h5A, 8'h96, 8'h00, 1'b0);
        close_out();
    end
endmodule
